// [hw/fqc_pkg.sv]
// Package of constants and types for the frame queue command and pointer block.
package fqc_pkg;

  // Register offsets (byte addresses of the 16-bit registers).
  localparam logic [3:0] FQC_OFF_TXQCMD = 4'h0;
  localparam logic [3:0] FQC_OFF_RXQCMD = 4'h2;
  localparam logic [3:0] FQC_OFF_TXPTR  = 4'h4;
  localparam logic [3:0] FQC_OFF_RXPTR  = 4'h6;
  localparam logic [3:0] FQC_OFF_QDL    = 4'h8;
  localparam logic [3:0] FQC_OFF_QDH    = 4'hA;

  // Field positions.
  localparam int FQC_CMD_BIT   = 0;
  localparam int FQC_AINC_BIT  = 14;
  localparam int FQC_PTR_W     = 11;

  // Reset values.
  localparam logic [10:0] FQC_PTR_RST  = 11'h000;
  localparam logic        FQC_AINC_RST = 1'b0;
  localparam logic        FQC_CMD_RST  = 1'b0;

  // Queue size in bytes and address width.
  localparam int FQC_QBYTES = 4096;
  localparam int FQC_QAW    = 12;

  // Access size codes.
  typedef enum logic [1:0] {
    FQC_SZ_BYTE  = 2'b00,
    FQC_SZ_WORD  = 2'b01,
    FQC_SZ_DWORD = 2'b10
  } fqc_size_type;

  // Command engine states.
  typedef enum logic [1:0] {
    FQC_IDLE = 2'b00,
    FQC_BUSY = 2'b01,
    FQC_DONE = 2'b10
  } fqc_cmd_state_type;

endpackage

// [hw/fqc_ptr_if.sv]
// Interface carrying one queue pointer channel between top and pointer unit.
`timescale 1ns/1ps
`default_nettype none
interface fqc_ptr_if;
  logic        wr_en;
  logic [15:0] wr_data;
  logic        step;
  logic [1:0]  step_size;
  logic        reload;
  logic [10:0] reload_val;
  logic [10:0] ptr;
  logic        auto_inc;
  modport owner (output wr_en, wr_data, step, step_size, reload, reload_val,
                 input ptr, auto_inc);
  modport unit  (input wr_en, wr_data, step, step_size, reload, reload_val,
                 output ptr, auto_inc);
endinterface
`default_nettype wire

// [hw/fqc_ptr_unit.sv]
// Pointer register with auto-increment and reload for one frame queue.
`timescale 1ns/1ps
`default_nettype none
module fqc_ptr_unit
  import fqc_pkg::*;
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Pointer channel
  fqc_ptr_if.unit  PIF
);

  typedef struct packed {
    logic [10:0] ptr;
    logic        ainc;
  } fqc_ptr_state_type;

  fqc_ptr_state_type st_ff;
  fqc_ptr_state_type nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (PIF.reload) begin
      nxt_st.ptr = PIF.reload_val;
    end else if (PIF.wr_en) begin
      nxt_st.ptr  = PIF.wr_data[FQC_PTR_W-1:0];
      nxt_st.ainc = PIF.wr_data[FQC_AINC_BIT];
    end else if (PIF.step && st_ff.ainc) begin
      case (PIF.step_size)
        FQC_SZ_BYTE:  nxt_st.ptr = st_ff.ptr + 11'h001;
        FQC_SZ_WORD:  nxt_st.ptr = st_ff.ptr + 11'h002;
        FQC_SZ_DWORD: nxt_st.ptr = st_ff.ptr + 11'h004;
        default:      nxt_st.ptr = st_ff.ptr;
      endcase
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      st_ff <= '{ptr: FQC_PTR_RST, ainc: FQC_AINC_RST};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign PIF.ptr      = st_ff.ptr;
  assign PIF.auto_inc = st_ff.ainc;

endmodule
`default_nettype wire

// [hw/fqc_top.sv]
// Frame queue command, pointer and data window logic of the queue manager.
//
// Functional notes
// - Writing 1 to transmit command bit 0 queues the prepared transmit frame.
// - Transmit enqueue bit stays set until the frame finished transmitting.
// - Writing 1 to receive command bit 0 releases the current receive frame.
// - Receive release bit stays set until the frame memory is freed.
// - Transmit pointer is bits 10..0, resets to zero, addresses TX buffer.
// - Transmit auto-increment bit 14 advances pointer on data window writes.
// - Automatic advance equals access size: one, two or four bytes.
// - Without transmit auto-increment the pointer changes only on writes and enqueue reloads.
// - Enqueue completion (TX_FRAME_DONE) reloads transmit pointer with next free transmit frame spot.
// - Receive auto-increment bit 14 advances pointer on data window reads.
// - Without receive auto-increment the pointer changes only on writes and release reloads.
// - Receive pointer is bits 10..0, resets to zero, addresses RX buffer.
// - Release completion (RX_FREE_DONE) reloads receive pointer with next receive frame location.
// - Data window reads come from receive queue, writes go to transmit queue.
// - Each queue holds 4096 bytes for payload and control or status word.
`timescale 1ns/1ps
`default_nettype none
module fqc_top
  import fqc_pkg::*;
#(
  parameter int QBYTES = FQC_QBYTES
)
(
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        RST,
  // Host register port
  input  wire logic        REG_SEL,
  input  wire logic        REG_WR,
  input  wire logic [3:0]  REG_ADDR,
  input  wire logic [1:0]  REG_SIZE,
  input  wire logic [31:0] REG_WDATA,
  output logic      [31:0] REG_RDATA,
  // Transmit side of the datapath
  output logic             TX_FRAME_GO,
  input  wire logic        TX_FRAME_DONE,
  input  wire logic [10:0] TX_NEXT_LOC,
  input  wire logic [11:0] TX_RD_ADDR,
  output logic      [7:0]  TX_RD_DATA,
  // Receive side of the datapath
  output logic             RX_FRAME_FREE,
  input  wire logic        RX_FREE_DONE,
  input  wire logic [10:0] RX_NEXT_LOC,
  input  wire logic        RX_WR_EN,
  input  wire logic [11:0] RX_WR_ADDR,
  input  wire logic [7:0]  RX_WR_DATA
);

  localparam int AW = $clog2(QBYTES);

  typedef struct packed {
    fqc_cmd_state_type tx_st;
    fqc_cmd_state_type rx_st;
    logic [31:0]       rdata;
    logic [7:0]        txrd;
  } fqc_top_state_type;

  fqc_top_state_type st_ff;
  fqc_top_state_type nxt_st;

  logic [7:0] tx_mem [QBYTES];
  logic [7:0] rx_mem [QBYTES];

  fqc_ptr_if tx_pif ();
  fqc_ptr_if rx_pif ();

  logic       acc_wr;
  logic       acc_rd;
  logic       hit_qd;
  logic       hit_qdh;
  logic [3:0] nbytes;
  logic [AW-1:0] tx_base;
  logic [AW-1:0] rx_base;
  logic [15:0] tx_cmd_word;
  logic [15:0] rx_cmd_word;
  logic [15:0] tx_ptr_word;
  logic [15:0] rx_ptr_word;

  assign acc_wr  = REG_SEL && REG_WR;
  assign acc_rd  = REG_SEL && !REG_WR;
  assign hit_qd  = (REG_ADDR == FQC_OFF_QDL) || (REG_ADDR == FQC_OFF_QDH);
  assign hit_qdh = (REG_ADDR == FQC_OFF_QDH);

  always_comb begin
    case (REG_SIZE)
      FQC_SZ_BYTE:  nbytes = 4'h1;
      FQC_SZ_WORD:  nbytes = 4'h2;
      FQC_SZ_DWORD: nbytes = 4'h4;
      default:      nbytes = 4'h0;
    endcase
  end

  // A high-word access starts two bytes past the pointer.
  assign tx_base = AW'({1'b0, tx_pif.ptr}) + (hit_qdh ? AW'(2) : AW'(0));
  assign rx_base = AW'({1'b0, rx_pif.ptr}) + (hit_qdh ? AW'(2) : AW'(0));

  assign tx_cmd_word = {15'h0000, st_ff.tx_st != FQC_IDLE};
  assign rx_cmd_word = {15'h0000, st_ff.rx_st != FQC_IDLE};
  assign tx_ptr_word = {1'b0, tx_pif.auto_inc, 3'h0, tx_pif.ptr};
  assign rx_ptr_word = {1'b0, rx_pif.auto_inc, 3'h0, rx_pif.ptr};

  assign tx_pif.wr_en      = acc_wr && (REG_ADDR == FQC_OFF_TXPTR);
  assign tx_pif.wr_data    = REG_WDATA[15:0];
  assign tx_pif.step       = acc_wr && hit_qd;
  assign tx_pif.step_size  = REG_SIZE;
  assign tx_pif.reload     = (st_ff.tx_st == FQC_BUSY) && TX_FRAME_DONE;
  assign tx_pif.reload_val = TX_NEXT_LOC;

  assign rx_pif.wr_en      = acc_wr && (REG_ADDR == FQC_OFF_RXPTR);
  assign rx_pif.wr_data    = REG_WDATA[15:0];
  assign rx_pif.step       = acc_rd && hit_qd;
  assign rx_pif.step_size  = REG_SIZE;
  assign rx_pif.reload     = (st_ff.rx_st == FQC_BUSY) && RX_FREE_DONE;
  assign rx_pif.reload_val = RX_NEXT_LOC;

  fqc_ptr_unit u_tx_ptr (
    .CLK (CLK),
    .RST (RST),
    .PIF (tx_pif)
  );

  fqc_ptr_unit u_rx_ptr (
    .CLK (CLK),
    .RST (RST),
    .PIF (rx_pif)
  );

  always_comb begin
    nxt_st = st_ff;
    nxt_st.txrd = tx_mem[TX_RD_ADDR[AW-1:0]];
    case (st_ff.tx_st)
      FQC_IDLE: begin
        if (acc_wr && REG_ADDR == FQC_OFF_TXQCMD && REG_WDATA[FQC_CMD_BIT]) begin
          nxt_st.tx_st = FQC_BUSY;
        end
      end
      FQC_BUSY: begin
        if (TX_FRAME_DONE) begin
          nxt_st.tx_st = FQC_IDLE;
        end
      end
      default: nxt_st.tx_st = FQC_IDLE;
    endcase
    case (st_ff.rx_st)
      FQC_IDLE: begin
        if (acc_wr && REG_ADDR == FQC_OFF_RXQCMD && REG_WDATA[FQC_CMD_BIT]) begin
          nxt_st.rx_st = FQC_BUSY;
        end
      end
      FQC_BUSY: begin
        if (RX_FREE_DONE) begin
          nxt_st.rx_st = FQC_IDLE;
        end
      end
      default: nxt_st.rx_st = FQC_IDLE;
    endcase
    if (acc_rd) begin
      nxt_st.rdata = 32'h0000_0000;
      case (REG_ADDR)
        FQC_OFF_TXQCMD: nxt_st.rdata = {16'h0000, tx_cmd_word};
        FQC_OFF_RXQCMD: nxt_st.rdata = {16'h0000, rx_cmd_word};
        FQC_OFF_TXPTR:  nxt_st.rdata = {16'h0000, tx_ptr_word};
        FQC_OFF_RXPTR:  nxt_st.rdata = {16'h0000, rx_ptr_word};
        FQC_OFF_QDL, FQC_OFF_QDH: begin
          for (int i = 0; i < 4; i++) begin
            if (4'(i) < nbytes) begin
              nxt_st.rdata[8*i +: 8] = rx_mem[rx_base + AW'(i)];
            end
          end
        end
        default: nxt_st.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      st_ff <= '{tx_st: FQC_IDLE, rx_st: FQC_IDLE,
                 rdata: 32'h0000_0000, txrd: 8'h00};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Memories hold no reset so they can map onto block RAM.
  always_ff @(posedge CLK) begin
    if (acc_wr && hit_qd) begin
      for (int i = 0; i < 4; i++) begin
        if (4'(i) < nbytes) begin
          tx_mem[tx_base + AW'(i)] <= REG_WDATA[8*i +: 8];
        end
      end
    end
    if (RX_WR_EN) begin
      rx_mem[RX_WR_ADDR[AW-1:0]] <= RX_WR_DATA;
    end
  end

  assign REG_RDATA     = st_ff.rdata;
  assign TX_RD_DATA    = st_ff.txrd;
  assign TX_FRAME_GO   = (st_ff.tx_st == FQC_BUSY);
  assign RX_FRAME_FREE = (st_ff.rx_st == FQC_BUSY);

endmodule
`default_nettype wire

// [sim/fqc_top_asserts.sv]
// Checker for the frame queue command and pointer block.
`timescale 1ns/1ps
`default_nettype none
module fqc_top_asserts
  import fqc_pkg::*;
#(
  parameter int QBYTES = FQC_QBYTES
)
(
  // Clock and reset
  input wire logic        CLK,
  input wire logic        RST,
  // Host port
  input wire logic        REG_SEL,
  input wire logic        REG_WR,
  input wire logic [3:0]  REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic [31:0] REG_RDATA,
  // Command handshakes
  input wire logic        TX_FRAME_GO,
  input wire logic        TX_FRAME_DONE,
  input wire logic        RX_FRAME_FREE,
  input wire logic        RX_FREE_DONE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  sequence wr_s(logic [3:0] a);
    REG_SEL && REG_WR && REG_ADDR == a && REG_WDATA[0];
  endsequence
  sequence rd_s(logic [3:0] a);
    REG_SEL && !REG_WR && REG_ADDR == a;
  endsequence
  tx_go_set_a: assert property (wr_s(4'h0) ##0 !TX_FRAME_DONE |=> TX_FRAME_GO)
    else $error("enqueue not taken");
  tx_go_hold_a: assert property (TX_FRAME_GO && !TX_FRAME_DONE |=> TX_FRAME_GO)
    else $error("enqueue bit dropped early");
  tx_go_clr_a: assert property (TX_FRAME_GO && TX_FRAME_DONE |=> !TX_FRAME_GO)
    else $error("enqueue bit not cleared");
  tx_go_cause_a: assert property ($rose(TX_FRAME_GO) |-> $past(REG_SEL && REG_WR && REG_ADDR == 4'h0 && REG_WDATA[0]))
    else $error("enqueue without write of one");
  rx_free_set_a: assert property (wr_s(4'h2) ##0 !RX_FREE_DONE |=> RX_FRAME_FREE)
    else $error("release not taken");
  rx_free_hold_a: assert property (RX_FRAME_FREE && !RX_FREE_DONE |=> RX_FRAME_FREE)
    else $error("release bit dropped early");
  rx_free_clr_a: assert property (RX_FRAME_FREE && RX_FREE_DONE |=> !RX_FRAME_FREE)
    else $error("release bit not cleared");
  txcmd_rsvd_a: assert property (rd_s(4'h0) |=> REG_RDATA[31:1] == 31'h0)
    else $error("command reserved bits set");
  rxptr_rsvd_a: assert property (rd_s(4'h6) |=> !REG_RDATA[15] && REG_RDATA[13:11] == 3'h0)
    else $error("pointer reserved bits set");
endmodule
bind fqc_top fqc_top_asserts #(.QBYTES(QBYTES)) i_chk (.CLK(CLK), .RST(RST),
  .REG_SEL(REG_SEL), .REG_WR(REG_WR), .REG_ADDR(REG_ADDR),
  .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .TX_FRAME_GO(TX_FRAME_GO),
  .TX_FRAME_DONE(TX_FRAME_DONE), .RX_FRAME_FREE(RX_FRAME_FREE),
  .RX_FREE_DONE(RX_FREE_DONE));
`default_nettype wire

// [sim/fqc_dp_model.sv]
// Datapath stand-in that finishes a queued command after a set delay.
`timescale 1ns/1ps
`default_nettype none
module fqc_dp_model (
  // Clock and reset
  input  wire logic       CLK,
  input  wire logic       RST,
  // Command handshake
  input  wire logic       REQ,
  input  wire logic [7:0] DLY,
  output logic            DONE
);
  logic [7:0] cnt;
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      cnt  <= 8'h00;
      DONE <= 1'b0;
    end else begin
      DONE <= 1'b0;
      cnt  <= 8'h00;
      if (REQ && !DONE && cnt == DLY) begin
        DONE <= 1'b1;
      end else if (REQ && !DONE) begin
        cnt <= cnt + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// [sim/testbench.sv]
// Self-checking bench for the frame queue command and pointer block.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import fqc_pkg::*;
  logic        CLK, RST, sel, wr, go, fr, txd, rxd, rwe;
  logic [1:0]  sz;
  logic [3:0]  adr;
  logic [7:0]  transmit_queue, rwd;
  logic [11:0] tra, rwa;
  logic [31:0] wd, rdat, r;
  logic [7:0]  dly [2];
  logic [10:0] nl [2];
  logic        ai [2];
  int          err_total, total_checks, cyc;
  fqc_top i_dut (.CLK(CLK), .RST(RST), .REG_SEL(sel), .REG_WR(wr),
    .REG_ADDR(adr), .REG_SIZE(sz), .REG_WDATA(wd), .REG_RDATA(rdat),
    .TX_FRAME_GO(go), .TX_FRAME_DONE(txd), .TX_NEXT_LOC(nl[0]),
    .TX_RD_ADDR(tra), .TX_RD_DATA(transmit_queue), .RX_FRAME_FREE(fr),
    .RX_FREE_DONE(rxd), .RX_NEXT_LOC(nl[1]), .RX_WR_EN(rwe),
    .RX_WR_ADDR(rwa), .RX_WR_DATA(rwd));
  fqc_dp_model i_txm (.CLK(CLK), .RST(RST), .REQ(go), .DLY(dly[0]),
    .DONE(txd));
  fqc_dp_model i_rxm (.CLK(CLK), .RST(RST), .REQ(fr), .DLY(dly[1]),
    .DONE(rxd));
  initial begin
    CLK = 1'b0;
    forever #25 CLK = ~CLK;
  end
  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      close_out();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic acc(input logic w, input logic [3:0] a,
                     input logic [1:0] s, input logic [31:0] d);
    @(posedge CLK);
    #2;
    sel = 1'b1;
    wr  = w;
    adr = a;
    sz  = s;
    wd  = d;
    @(posedge CLK);
    #2;
    sel = 1'b0;
    r   = rdat;
  endtask
  function automatic logic [31:0] pimg(input logic a, input logic [10:0] p);
    return {17'h0, a, 3'h0, p};
  endfunction
  task automatic win(input int q, input logic [1:0] s, input logic a);
    logic [10:0] p, b;
    logic [31:0] d, m;
    logic [3:0]  o;
    int          n;
    n = 1 << s;
    p = 11'($urandom % 2040);
    d = $urandom;
    o = ($urandom % 2 == 0) ? 4'h8 : 4'hA;
    b = p + ((o == 4'hA) ? 11'h002 : 11'h000);
    m = 32'hFFFFFFFF >> (32 - 8 * n);
    ai[q] = a;
    acc(1'b1, 4'h4 + 4'(2 * q), FQC_SZ_WORD, pimg(a, p));
    for (int i = 0; i < n && q == 1; i++) begin
      @(posedge CLK);
      #2;
      rwe = 1'b1;
      rwa = {1'b0, b + 11'(i)};
      rwd = d[8 * i +: 8];
    end
    @(posedge CLK);
    #2;
    rwe = 1'b0;
    acc(q == 0, o, s, d);
    if (q == 1) chk(r & m, d & m);
    acc(1'b0, 4'h4 + 4'(2 * q), FQC_SZ_WORD, 32'h0);
    chk(r, pimg(a, a ? p + 11'(n) : p));
    for (int i = 0; i < n && q == 0; i++) begin
      tra = {1'b0, b + 11'(i)};
      @(posedge CLK);
      #2;
      chk({24'h0, transmit_queue}, {24'h0, d[8 * i +: 8]});
    end
  endtask
  task automatic cmd(input int q, input logic [7:0] dl);
    int k;
    dly[q] = dl;
    nl[q]  = 11'($urandom);
    acc(1'b1, 4'(2 * q), FQC_SZ_WORD, 32'hFFFE);
    acc(1'b0, 4'(2 * q), FQC_SZ_WORD, 32'h0);
    chk(r, 32'h0);
    acc(1'b1, 4'(2 * q), FQC_SZ_WORD, 32'h1);
    acc(1'b0, 4'(2 * q), FQC_SZ_WORD, 32'h0);
    chk(r, 32'h1);
    chk({31'h0, q == 1 ? fr : go}, 32'h1);
    k = 0;
    while (r[0] !== 1'b0 && k < 100) begin
      acc(1'b0, 4'(2 * q), FQC_SZ_WORD, 32'h0);
      k++;
    end
    chk(r, 32'h0);
    acc(1'b0, 4'h4 + 4'(2 * q), FQC_SZ_WORD, 32'h0);
    chk(r, pimg(ai[q], nl[q]));
  endtask
  initial begin
    void'($urandom(11153));
    {RST, sel, wr, adr, sz, wd, tra, rwe, rwa, rwd} = '0;
    RST = 1'b1;
    {dly[0], dly[1], nl[0], nl[1], ai[0], ai[1]} = '0;
    {cyc, err_total, total_checks} = '0;
    repeat (4) @(posedge CLK);
    #2;
    RST = 1'b0;
    for (int a = 0; a < 14; a += 2) begin
      acc(1'b0, 4'(a == 8 || a == 10 ? 12 : a), FQC_SZ_WORD, 32'h0);
      chk(r, 32'h0);
    end
    $display("reset test finished");
    repeat (3) for (int q = 0; q < 2; q++) for (int s = 0; s < 3; s++) begin
      win(q, 2'(s), 1'b1);
      win(q, 2'(s), 1'b0);
    end
    acc(1'b1, 4'h6, FQC_SZ_WORD, pimg(1'b1, 11'h010));
    acc(1'b0, 4'h8, 2'b11, 32'h0);
    chk(r, 32'h0);
    acc(1'b0, 4'h6, FQC_SZ_WORD, 32'h0);
    chk(r, pimg(1'b1, 11'h010));
    $display("window test finished");
    for (int q = 0; q < 2; q++) begin
      win(q, FQC_SZ_WORD, q[0]);
      cmd(q, 8'h04);
      cmd(q, 8'h1E);
    end
    $display("command test finished");
    close_out();
  end
endmodule
`default_nettype wire
